// ==== src/cps_inputs.sv ====
// Discrete program select, permit and zero-offset inputs with APB registers
`include "cps_map.svh"
`default_nettype none
module cps_inputs #(
  parameter int DEBOUNCE_CYC = `CPS_DEBOUNCE_CYC,
  parameter int ZERO_CYC     = `CPS_ZERO_HOLD_CYC,
  parameter int FREEZE_CYC   = `CPS_FREEZE_CYC
) (
  input  wire logic        I_CLK,              // 25 MHz clock
  input  wire logic        I_SYS_RST,          // Sync reset, active high
  input  wire logic        I_CE,               // Clock enable
  input  wire logic        I_PSEL,             // APB select
  input  wire logic        I_PENABLE,          // APB enable
  input  wire logic        I_PWRITE,           // APB write
  input  wire logic [11:0] I_PADDR,            // APB byte address
  input  wire logic [31:0] I_PWDATA,           // APB write data
  output logic      [31:0] O_PRDATA,           // APB read data
  output logic             O_PREADY,           // APB ready
  output logic             O_PSLVERR,          // APB error
  input  wire logic [3:0]  I_PROGRAM_NUMBER,   // Pins, 1 = 24 V
  input  wire logic        I_PROGRAM_TAKE_STROBE, // Pin, 1 = 24 V
  input  wire logic        I_NETID_BIT3_INPUT, // Pin, 1 = 24 V / 0 = GND
  input  wire logic [2:0]  I_NETID_LOW,        // Netid bits 0..2
  input  wire logic        I_CHANGE_REQ,       // Parameter change request
  output logic             O_CHANGE_ACCEPT,    // Change accepted
  output logic             O_CHANGE_REJECT,    // Change rejected
  output logic      [3:0]  O_NETID,            // Effective network id
  output logic      [3:0]  O_ACTIVE_PROGRAM,   // Latched program
  output logic             O_PROGRAMMING_PERMIT, // Permit state
  output logic             O_RECALC,           // Cam table recompute pulse
  output logic             O_OUTPUTS_FROZEN    // Hold cam outputs
);
  import cps_pkg::*;

  localparam int NI = `CPS_NUM_INPUTS;
  logic [NI-1:0] raw;
  logic [NI-1:0] s1_ff, s2_ff, stable_ff, nxt_stable;
  logic [NI-1:0] prev_ff;
  logic [NI-1:0][19:0] cnt_ff, nxt_cnt;

  assign raw = {I_NETID_BIT3_INPUT, I_PROGRAM_TAKE_STROBE, I_PROGRAM_NUMBER};

  // Bounce filter: a level must stand for the whole window before it counts
  // Trade-off: every take and zero request is delayed by the same window
  genvar g;
  generate
    for (g = 0; g < NI; g++) begin : g_deb
      always_comb begin
        nxt_cnt[g]    = cnt_ff[g];
        nxt_stable[g] = stable_ff[g];
        if (s2_ff[g] == stable_ff[g]) begin
          nxt_cnt[g] = 20'h00000;
        end else if (cnt_ff[g] >= 20'(DEBOUNCE_CYC - 1)) begin
          nxt_cnt[g]    = 20'h00000;
          nxt_stable[g] = s2_ff[g];
        end else begin
          nxt_cnt[g] = cnt_ff[g] + 20'h00001;
        end
      end
    end
  endgenerate

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      s1_ff     <= '0;
      s2_ff     <= '0;
      stable_ff <= '0;
      prev_ff   <= '0;
      cnt_ff    <= '0;
    end else if (I_CE) begin
      s1_ff     <= raw;
      s2_ff     <= s1_ff;
      stable_ff <= nxt_stable;
      prev_ff   <= stable_ff;
      cnt_ff    <= nxt_cnt;
    end
  end

  // Control register
  logic [1:0]  ctrl_ff, nxt_ctrl;
  logic [3:0]  prog_ff, nxt_prog;
  logic        take_rise, zero_opt, rel_opt, pin_low;
  logic [3:0]  prog_val;
  logic        wr;

  assign wr = I_PSEL & I_PENABLE & I_PWRITE;
  assign rel_opt  = ctrl_ff[`CPS_CTRL_RELEASE];
  assign zero_opt = ctrl_ff[`CPS_CTRL_ZERO];
  assign take_rise = stable_ff[4] & ~prev_ff[4];
  assign pin_low   = ~stable_ff[5];
  // Zero option drops the top bit, leaving programs 0..7
  assign prog_val = zero_opt ? {1'b0, stable_ff[2:0]}
                             : stable_ff[3:0];

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_prog = prog_ff;
    if (wr && I_PADDR == `CPS_PADDR_CTRL) begin
      nxt_ctrl = I_PWDATA[1:0];
    end
    if (take_rise) begin
      nxt_prog = prog_val;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ctrl_ff <= 2'(`CPS_CTRL_RESET);
      prog_ff <= 4'h0;
    end else if (I_CE) begin
      ctrl_ff <= nxt_ctrl;
      prog_ff <= nxt_prog;
    end
  end

  // Permit: grounded pin allows programming; open pin (reads high) locks.
  // Without the release option the pin is a netid bit and never locks.
  logic permit;
  assign permit = rel_opt ? pin_low : 1'b1;
  assign O_NETID = rel_opt ? {1'b0, I_NETID_LOW}
                           : {stable_ff[5], I_NETID_LOW};

  // Zero-offset request qualifier and recompute sequencer
  // Limitation: a request already high when the option is set is ignored
  cps_zero_type st_ff, nxt_st;
  logic [23:0]  zc_ff, nxt_zc;
  logic         recalc_ff, nxt_recalc;

  always_comb begin
    nxt_st     = st_ff;
    nxt_zc     = zc_ff;
    nxt_recalc = 1'b0;
    unique case (st_ff)
      CPS_IDLE: begin
        nxt_zc = 24'h000000;
        if (zero_opt && stable_ff[3] && !prev_ff[3]) begin
          nxt_st = CPS_QUAL;
        end
      end
      CPS_QUAL: begin
        if (!stable_ff[3] || !zero_opt) begin
          nxt_st = CPS_IDLE;
        end else if (zc_ff >= 24'(ZERO_CYC - 1)) begin
          nxt_st     = CPS_RECALC;
          nxt_zc     = 24'h000000;
          nxt_recalc = 1'b1;
        end else begin
          nxt_zc = zc_ff + 24'h000001;
        end
      end
      CPS_RECALC: begin
        // Outputs held while tables are rebuilt; request must drop to re-arm
        if (zc_ff >= 24'(FREEZE_CYC - 1)) begin
          if (!stable_ff[3]) begin
            nxt_st = CPS_IDLE;
          end
        end else begin
          nxt_zc = zc_ff + 24'h000001;
        end
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      st_ff     <= CPS_IDLE;
      zc_ff     <= 24'h000000;
      recalc_ff <= 1'b0;
    end else if (I_CE) begin
      st_ff     <= nxt_st;
      zc_ff     <= nxt_zc;
      recalc_ff <= nxt_recalc;
    end
  end

  assign O_RECALC         = recalc_ff;
  assign O_OUTPUTS_FROZEN = (st_ff == CPS_RECALC) &&
                            (zc_ff < 24'(FREEZE_CYC - 1));
  assign O_ACTIVE_PROGRAM = prog_ff;
  assign O_PROGRAMMING_PERMIT = permit;
  assign O_CHANGE_ACCEPT  = I_CHANGE_REQ & permit;
  assign O_CHANGE_REJECT  = I_CHANGE_REQ & ~permit;

  // APB: zero-wait slave, unmapped address reads zero with error
  logic mapped;
  assign mapped = (I_PADDR == `CPS_PADDR_CTRL) ||
                  (I_PADDR == `CPS_PADDR_STATUS) ||
                  (I_PADDR == `CPS_PADDR_PROGRAM);
  assign O_PREADY  = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

  // Read data is captured in the setup phase, so the access phase shows it
  // from a flip-flop without costing a wait state
  logic        rd_setup;
  logic [31:0] prdata_ff, nxt_prdata;
  assign rd_setup = I_PSEL & ~I_PENABLE & ~I_PWRITE;

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (rd_setup) begin
      unique case (I_PADDR)
        `CPS_PADDR_CTRL:    nxt_prdata = {30'h0, ctrl_ff};
        `CPS_PADDR_STATUS:  nxt_prdata = {26'h0, O_OUTPUTS_FROZEN,
                                          st_ff == CPS_QUAL, stable_ff[5],
                                          stable_ff[4], stable_ff[3],
                                          permit};
        `CPS_PADDR_PROGRAM: nxt_prdata = {28'h0, prog_ff};
        default:            nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      prdata_ff <= 32'h0000_0000;
    end else if (I_CE) begin
      prdata_ff <= nxt_prdata;
    end
  end

  assign O_PRDATA = prdata_ff;
endmodule : cps_inputs
`default_nettype wire

// ==== src/cps_map.svh ====
// Constants for the cam program select input block
`ifndef CPS_MAP_SVH
`define CPS_MAP_SVH
`define CPS_PADDR_CTRL      12'h000
`define CPS_PADDR_STATUS    12'h004
`define CPS_PADDR_PROGRAM   12'h008
`define CPS_CTRL_RELEASE    0
`define CPS_CTRL_ZERO       1
`define CPS_CTRL_RESET      32'h0000_0000
`define CPS_CLK_HZ          25000000
`define CPS_DEBOUNCE_US     1000
`define CPS_DEBOUNCE_CYC    ((`CPS_CLK_HZ / 1000000) * `CPS_DEBOUNCE_US)
`define CPS_ZERO_HOLD_MS    100
`define CPS_ZERO_HOLD_CYC   ((`CPS_CLK_HZ / 1000) * `CPS_ZERO_HOLD_MS)
`define CPS_FREEZE_US       1000
`define CPS_FREEZE_CYC      ((`CPS_CLK_HZ / 1000000) * `CPS_FREEZE_US)
`define CPS_NUM_INPUTS      6
`endif

// ==== src/cps_pkg.sv ====
// Types for the cam program select input block
`default_nettype none
package cps_pkg;
  typedef enum logic [2:0] {
    CPS_IDLE   = 3'b001,
    CPS_QUAL   = 3'b010,
    CPS_RECALC = 3'b100
  } cps_zero_type;
endpackage : cps_pkg
`default_nettype wire

// ==== testbench/cps_sw.sv ====
// Machine-side switch model with contact bounce
`default_nettype none
module cps_sw (
  input  wire logic       clk, // Sample clock
  input  wire logic [5:0] lvl, // Commanded levels
  output var  logic [5:0] pin  // Wired levels
);
  timeunit 1ns; timeprecision 1ns;
  logic [5:0] last = 6'h20, msk = 6'h00;
  logic [1:0] bnc = 2'h0;
  initial pin = 6'h20;
  // Changed contacts chatter twice before settling, as real ones do
  always @(posedge clk) begin
    last <= lvl;
    msk  <= (lvl != last) ? lvl ^ last : msk;
    bnc  <= (lvl != last) ? 2'h2 : (bnc != 2'h0) ? bnc - 2'h1 : 2'h0;
    pin  <= (bnc != 2'h0) ? pin ^ msk : lvl;
  end
endmodule : cps_sw
`default_nettype wire

// ==== testbench/cps_inputs_chk.sv ====
// Port checker for the program select input block
`default_nettype none
module cps_inputs_chk (
  input wire logic       I_CLK,                 // Block clock
  input wire logic       I_SYS_RST,             // Sync reset, active high
  input wire logic       I_CHANGE_REQ,          // Change request
  input wire logic       O_CHANGE_ACCEPT,       // Change accepted
  input wire logic       O_CHANGE_REJECT,       // Change rejected
  input wire logic       O_PROGRAMMING_PERMIT,  // Permit state
  input wire logic       O_RECALC,              // Recompute pulse
  input wire logic       O_OUTPUTS_FROZEN,      // Outputs held
  input wire logic       I_NETID_BIT3_INPUT,    // Permit pin
  input wire logic       I_PROGRAM_TAKE_STROBE, // Take strobe pin
  input wire logic [2:0] I_NETID_LOW,           // Netid bits 0..2
  input wire logic [3:0] O_NETID,               // Effective netid
  input wire logic [3:0] I_PROGRAM_NUMBER,      // Program pins
  input wire logic [3:0] O_ACTIVE_PROGRAM       // Latched program
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  property p_acc; {O_CHANGE_ACCEPT, O_CHANGE_REJECT} == {I_CHANGE_REQ &
    O_PROGRAMMING_PERMIT, I_CHANGE_REQ & !O_PROGRAMMING_PERMIT}; endproperty
  a_acc: assert property (p_acc) else $error("change answer");
  property p_nid; O_NETID[2:0] == I_NETID_LOW; endproperty
  a_nid: assert property (p_nid) else $error("netid");
  property p_lock; $fell(O_PROGRAMMING_PERMIT) |->
    $past(I_NETID_BIT3_INPUT, 3); endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_take; $changed(O_ACTIVE_PROGRAM) |->
    $past(I_PROGRAM_TAKE_STROBE, 2); endproperty
  a_take: assert property (p_take) else $error("take");
  // A take must rest on a strobe level older than the debounce span
  property p_bnc; $changed(O_ACTIVE_PROGRAM) |->
    $past(I_PROGRAM_TAKE_STROBE, 5); endproperty
  a_bnc: assert property (p_bnc) else $error("bounce");
  property p_dec; $changed(O_ACTIVE_PROGRAM) |->
    O_ACTIVE_PROGRAM[2:0] == $past(I_PROGRAM_NUMBER[2:0], 3); endproperty
  a_dec: assert property (p_dec) else $error("decode");
  property p_zero; O_RECALC |-> $past(I_PROGRAM_NUMBER[3], 22); endproperty
  a_zero: assert property (p_zero) else $error("zero");
  property p_frz; O_RECALC |=> O_OUTPUTS_FROZEN [*3]; endproperty
  a_frz: assert property (p_frz) else $error("freeze");
endmodule : cps_inputs_chk
bind cps_inputs cps_inputs_chk i_cps_inputs_chk (
  .I_CLK                 (I_CLK),
  .I_SYS_RST             (I_SYS_RST),
  .I_CHANGE_REQ          (I_CHANGE_REQ),
  .O_CHANGE_ACCEPT       (O_CHANGE_ACCEPT),
  .O_CHANGE_REJECT       (O_CHANGE_REJECT),
  .O_PROGRAMMING_PERMIT  (O_PROGRAMMING_PERMIT),
  .O_RECALC              (O_RECALC),
  .O_OUTPUTS_FROZEN      (O_OUTPUTS_FROZEN),
  .I_NETID_BIT3_INPUT    (I_NETID_BIT3_INPUT),
  .I_PROGRAM_TAKE_STROBE (I_PROGRAM_TAKE_STROBE),
  .I_NETID_LOW           (I_NETID_LOW),
  .O_NETID               (O_NETID),
  .I_PROGRAM_NUMBER      (I_PROGRAM_NUMBER),
  .O_ACTIVE_PROGRAM      (O_ACTIVE_PROGRAM)
);
`default_nettype wire

// ==== testbench/cps_inputs_tb.sv ====
// Testbench for the program select input block
`include "cps_map.svh"
`default_nettype none
module cps_inputs_tb;
  timeunit 1ns; timeprecision 1ns;
  logic        clk = 0, rst = 1, psel = 0, pen = 0, pw = 0, req = 0, e, f;
  logic        rdy, err, acc, rej, prm, rc, frz;
  logic        ce = 1;
  logic [3:0]  nid, act;
  logic [3:0]  pl [2] = '{4'hA, 4'h5};
  logic [11:0] pa = 12'h000;
  logic [31:0] wd = 32'h0, q, rd;
  logic [5:0]  lvl = 6'h20;
  wire  logic [5:0] pin;
  int          error_cnt = 0, checks_done = 0, i;
  initial forever #20 clk = ~clk;
  cps_sw i_cps_sw (.clk(clk), .lvl(lvl), .pin(pin));
  cps_inputs #(.DEBOUNCE_CYC(4), .ZERO_CYC(20), .FREEZE_CYC(5)) i_cps_inputs (
    .I_CLK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_PSEL(psel),
    .I_PENABLE(pen), .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(wd),
    .O_PRDATA(rd), .O_PREADY(rdy), .O_PSLVERR(err),
    .I_PROGRAM_NUMBER(pin[3:0]), .I_PROGRAM_TAKE_STROBE(pin[4]),
    .I_NETID_BIT3_INPUT(pin[5]), .I_NETID_LOW(3'h5), .I_CHANGE_REQ(req),
    .O_CHANGE_ACCEPT(acc), .O_CHANGE_REJECT(rej), .O_NETID(nid),
    .O_ACTIVE_PROGRAM(act), .O_PROGRAMMING_PERMIT(prm), .O_RECALC(rc),
    .O_OUTPUTS_FROZEN(frz));
  task automatic chk(input logic [31:0] s, x);
    checks_done++;
    if (s !== x) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, s, x);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // Request held until pready is seen at a rising edge; data taken there.
  // The leading edge keeps back-to-back calls from reassigning psel at once.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pw   <= w;
    pa   <= a;
    wd   <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    q = rd;
    e = err;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic take(input logic [3:0] p);
    lvl[3:0] <= p;
    cyc(10);
    lvl[4] <= 1;
    cyc(15);
    lvl[4] <= 0;
    cyc(12);
  endtask : take
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  initial begin
    cyc(5000);
    error_cnt++;
    stop_test;
  end
  initial begin
    cyc(3);
    rst <= 0;
    apb(1, 12'h0FC, 32'hFFFF_FFFF);
    chk(e, 1);
    apb(0, `CPS_PADDR_CTRL, 0);
    chk(q, `CPS_CTRL_RESET);
    apb(0, `CPS_PADDR_PROGRAM, 0);
    chk(q, 0);
    chk(prm, 1);
    $display("Test reset done");
    foreach (pl[k]) begin
      take(pl[k]);
      chk(act, pl[k]);
      apb(0, `CPS_PADDR_PROGRAM, 0);
      chk(q, pl[k]);
    end
    $display("Test program done");
    lvl[5] <= 0;
    apb(1, `CPS_PADDR_CTRL, 1);
    cyc(12);
    req <= 1;
    cyc(1);
    chk({prm, acc, nid}, 6'h35);
    lvl[5] <= 1;
    cyc(12);
    chk({prm, acc, rej}, 3'h1);
    req <= 0;
    apb(0, `CPS_PADDR_STATUS, 0);
    chk(q, 32'h0000_0008);
    $display("Test permit done");
    apb(1, `CPS_PADDR_CTRL, 2);
    lvl[3] <= 1;
    cyc(12);
    lvl[3] <= 0;
    f = 0;
    repeat (40) @(negedge clk) f |= rc;
    chk(f, 0);
    @(posedge clk) lvl[3:0] <= 4'hE;
    for (i = 0; i < 60 && rc !== 1'b1; i++) @(negedge clk);
    chk(rc, 1);
    @(negedge clk) chk(frz, 1);
    @(posedge clk) take(4'hE);
    chk(act, 4'h6);
    $display("Test zero offset done");
    ce <= 0;
    take(4'h3);
    ce <= 1;
    cyc(12);
    chk(act, 4'h6);
    $display("Test clock enable done");
    stop_test;
  end
endmodule : cps_inputs_tb
`default_nettype wire
